// [core/shutdown_steering_pkg.sv]
package shutdown_steering_pkg;

   // ------------------------------------------------------------
   // Register indices (each register is one byte wide, so the index
   // is used directly as the address)
   // ------------------------------------------------------------
   localparam logic [11:0] IDX_CONTROL = 12'h610;
   localparam logic [11:0] IDX_POLARITY = 12'h611;
   localparam logic [11:0] IDX_SHUTDOWN_LEVELS = 12'h612;
   localparam logic [11:0] IDX_SOURCE_ENABLE = 12'h613;
   localparam logic [11:0] IDX_STEERING = 12'h614;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTL_EN_BIT = 7;
   localparam int CTL_MODE_LSB = 0;
   localparam int POL_IN_BIT = 5;
   localparam int LVL_SHUTDOWN_BIT = 7;
   localparam int LVL_RESTART_BIT = 6;
   localparam int LVL_BD_LSB = 4;
   localparam int LVL_AC_LSB = 2;
   localparam int STR_OVR_LSB = 4;
   localparam int NUM_SOURCES = 7;
   localparam int NUM_OUTPUTS = 4;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [3:0] RST_POLARITY = 4'h0;
   localparam logic [1:0] RST_LEVEL = 2'h1;
   localparam logic [6:0] RST_SOURCES = 7'h00;
   localparam logic [7:0] RST_STEERING = 8'h00;
   // Sources that shut down on a high level: timers at bits 1..3
   localparam logic [6:0] ACTIVE_HIGH_SOURCES = 7'h0e;

   typedef enum logic [2:0] {
      MODE_STEER_ASYNC = 3'b000,
      MODE_STEER_SYNC = 3'b001,
      MODE_FULL_FWD = 3'b010,
      MODE_FULL_REV = 3'b011,
      MODE_HALF = 3'b100,
      MODE_PUSH_PULL = 3'b101,
      MODE_RSVD_6 = 3'b110,
      MODE_RSVD_7 = 3'b111
   } mode_t;

   typedef enum logic [1:0] {
      LEVEL_INACTIVE = 2'b00,
      LEVEL_TRISTATE = 2'b01,
      LEVEL_LOW = 2'b10,
      LEVEL_HIGH = 2'b11
   } level_t;

   typedef struct packed {
      logic logic_cell_result;
      logic comparator_two_result;
      logic comparator_one_result;
      logic timer_six_period_match;
      logic timer_four_period_match;
      logic timer_two_period_match;
      logic shutdown_pin_select;
   } sources_t;

   typedef struct packed {
      logic [3:0] level;
      logic [3:0] drive_en;
   } outputs_t;

endpackage

// [core/waveform_shutdown_steering.sv]
`timescale 1ns/10ps
// Overview of operation
// R01: Shutdown drives B and D per B/D level field: high, low, float, inactive.
// R02: Shutdown drives A and C per A/C level field: high, low, float, inactive.
// R03: Software may set shutdown status while disabled to force shutdown levels.
// R04: After status clears, outputs hold shutdown levels until next data rise.
// R05: Each shutdown source has an enable; disabled sources are ignored.
// R06: Pin, both comparators and logic cell shut down when low.
// R07: Timer two, four and six matches shut down when high.
// R08: Steered output carries data input, inverted by its polarity bit.
// R09: Unsteered output is driven to its override bit, ignoring polarity.
// R10: Steer and override bits apply only in the two steering modes.
// R11: In synchronous steering the steer-enable bits are double-buffered.
// R12: Mode 000 is async steering, 001 sync steering; others are bridges.
// R13: Each output has a polarity bit; one inverts, zero is normal.
// R14: Status reads one while shutdown is in effect; hardware sets it.
// R15: Auto-restart lets hardware leave shutdown; else software must clear.
// R16: Sync mode loads buffered steer bits on data rise; async is immediate.
// R17: Auto-restart clears status once all enabled sources go inactive.
module waveform_shutdown_steering (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clk_en,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Generator data and shutdown sources
   input wire logic waveform_gen_data,
   input wire shutdown_steering_pkg::sources_t shutdown_sources,
   // Power switch outputs
   output shutdown_steering_pkg::outputs_t switch_out
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Control and polarity
   logic enable_q;
   shutdown_steering_pkg::mode_t mode_q;
   logic [3:0] output_invert_q;

   // Shutdown status, restart and levels
   logic shutdown_q;
   logic restart_q;
   shutdown_steering_pkg::level_t bd_shutdown_level_q;
   shutdown_steering_pkg::level_t ac_shutdown_level_q;
   logic [6:0] source_shutdown_enable_q;

   // Steering: written buffer and the set the outputs use
   logic [3:0] override_level_q;
   logic [3:0] steer_buffer_q;
   logic [3:0] steer_enable_q;

   // Release tracking
   logic data_prev_q;
   logic hold_q;

   // Output flops
   logic [7:0] reg_rdata_q;
   shutdown_steering_pkg::outputs_t switch_out_q;

   // ------------------------------------------------------------
   // Decoded strobes and next values
   // ------------------------------------------------------------
   logic data_rise;
   logic [6:0] source_active;
   logic trip;
   logic wr_levels;
   logic wr_steer;
   logic steering_mode;
   logic shutdown_d;
   logic hold_d;
   logic [7:0] reg_rdata_d;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // One compare shared by every register, so a new register only
   // needs its index in the package
   function automatic logic is_write(input logic [11:0] addr,
                                     input logic [11:0] idx,
                                     input logic wr);
      return wr && (addr == idx);
   endfunction

   // ------------------------------------------------------------
   // Source qualification
   // ------------------------------------------------------------
   // The edge is taken against the registered copy, which reset clears, so a level that
   // is already high when reset lifts is taken for an edge
   assign data_rise = waveform_gen_data && !data_prev_q;

   // Active-low sources are inverted so every bit reads one when asserting
   assign source_active = shutdown_sources ^
      ~shutdown_steering_pkg::ACTIVE_HIGH_SOURCES; // R06 R07

   // Sources are level sensitive: one that stays asserted keeps
   // re-arming the status bit even after software has cleared it
   assign trip = |(source_active & source_shutdown_enable_q); // R05

   assign wr_levels = is_write(reg_addr,
      shutdown_steering_pkg::IDX_SHUTDOWN_LEVELS, reg_write);

   assign wr_steer = is_write(reg_addr,
      shutdown_steering_pkg::IDX_STEERING, reg_write);

   // Bridge modes ignore steer and override bits altogether
   assign steering_mode = (mode_q == shutdown_steering_pkg::MODE_STEER_ASYNC)
      || (mode_q == shutdown_steering_pkg::MODE_STEER_SYNC); // R10 R12

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         enable_q <= shutdown_steering_pkg::RST_CONTROL[
            shutdown_steering_pkg::CTL_EN_BIT];
         mode_q <= shutdown_steering_pkg::mode_t'(
            shutdown_steering_pkg::RST_CONTROL[2:0]);
         output_invert_q <= shutdown_steering_pkg::RST_POLARITY;
         restart_q <= 1'b0;
         bd_shutdown_level_q <= shutdown_steering_pkg::level_t'(
            shutdown_steering_pkg::RST_LEVEL);
         ac_shutdown_level_q <= shutdown_steering_pkg::level_t'(
            shutdown_steering_pkg::RST_LEVEL);
         source_shutdown_enable_q <= shutdown_steering_pkg::RST_SOURCES;
         override_level_q <= shutdown_steering_pkg::RST_STEERING[7:4];
         steer_buffer_q <= shutdown_steering_pkg::RST_STEERING[3:0];
      end else if (clk_en) begin
         // Reserved bits of every register read back as zero
         if (is_write(reg_addr, shutdown_steering_pkg::IDX_CONTROL,
                      reg_write)) begin
            enable_q <= reg_wdata[shutdown_steering_pkg::CTL_EN_BIT];
            mode_q <= shutdown_steering_pkg::mode_t'(reg_wdata[2:0]); // R12
         end

         if (is_write(reg_addr, shutdown_steering_pkg::IDX_POLARITY,
                      reg_write)) begin
            output_invert_q <= reg_wdata[3:0]; // R13
         end

         // Status bit 7 is owned by the shutdown block below
         if (wr_levels) begin
            restart_q <= reg_wdata[shutdown_steering_pkg::LVL_RESTART_BIT];
            bd_shutdown_level_q <= shutdown_steering_pkg::level_t'(
               reg_wdata[5:4]);
            ac_shutdown_level_q <= shutdown_steering_pkg::level_t'(
               reg_wdata[3:2]);
         end

         if (is_write(reg_addr, shutdown_steering_pkg::IDX_SOURCE_ENABLE,
                      reg_write)) begin
            source_shutdown_enable_q <= reg_wdata[6:0]; // R05
         end

         // Only the buffer is written; the active steer set follows it
         // in the double-buffer block
         if (wr_steer) begin
            override_level_q <= reg_wdata[7:4];
            steer_buffer_q <= reg_wdata[3:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Steer-enable double buffer
   // ------------------------------------------------------------
   // Sync mode waits for a data rise so a steer change never chops a
   // pulse in half; async mode passes the written value straight on.
   // A steer-bit write in sync mode stays off the outputs until the data next rises.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         steer_enable_q <= shutdown_steering_pkg::RST_STEERING[3:0];
      end else if (clk_en) begin
         if (mode_q != shutdown_steering_pkg::MODE_STEER_SYNC) begin
            steer_enable_q <= steer_buffer_q; // R16
         end else if (data_rise) begin
            steer_enable_q <= steer_buffer_q; // R11 R16
         end
      end
   end

   // ------------------------------------------------------------
   // Shutdown status and release
   // ------------------------------------------------------------
   // Set beats clear: while the module is enabled, a trip in the same
   // cycle as a software clear leaves the status set
   always_comb begin
      shutdown_d = shutdown_q;
      if (trip && enable_q) begin
         shutdown_d = 1'b1; // R14
      end else if (wr_levels) begin
         shutdown_d = reg_wdata[
            shutdown_steering_pkg::LVL_SHUTDOWN_BIT]; // R03 R15
      end else if (restart_q && !trip) begin
         shutdown_d = 1'b0; // R17
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         shutdown_q <= 1'b0;
      end else if (clk_en) begin
         shutdown_q <= shutdown_d;
      end
   end

   // Hold keeps the shutdown levels after the status clears, so a
   // restart never cuts into the middle of a data pulse; the cost is
   // that a stalled data input keeps the stage shut down
   always_comb begin
      hold_d = hold_q;
      if (shutdown_q) begin
         hold_d = 1'b1;
      end else if (data_rise) begin
         hold_d = 1'b0; // R04
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         data_prev_q <= 1'b0;
         hold_q <= 1'b0;
      end else if (clk_en) begin
         data_prev_q <= waveform_gen_data;
         hold_q <= hold_d;
      end
   end

   // ------------------------------------------------------------
   // Output stage
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < shutdown_steering_pkg::NUM_OUTPUTS; g++) begin : g_out
         // A and C are outputs 0 and 2, B and D are 1 and 3
         shutdown_steering_pkg::level_t lvl;
         logic norm;
         logic inactive;
         assign lvl = (g % 2 == 0) ? ac_shutdown_level_q
                                   : bd_shutdown_level_q;
         assign inactive = output_invert_q[g]; // R13

         // Bridge modes pass the data with polarity only; the bridge
         // pattern itself is formed outside this block
         always_comb begin
            if (!steering_mode) begin
               norm = waveform_gen_data ^ output_invert_q[g];
            end else if (steer_enable_q[g]) begin
               norm = waveform_gen_data ^ output_invert_q[g]; // R08
            end else begin
               norm = override_level_q[g]; // R09
            end
         end

         // A disabled module that is not shut down floats every output,
         // so the switches fall back to their own gate pulls
         always_ff @(posedge clk_sys) begin
            if (!resetn) begin
               switch_out_q.level[g] <= 1'b0;
               switch_out_q.drive_en[g] <= 1'b0;
            end else if (clk_en) begin
               if (shutdown_q || hold_q) begin
                  // Level fields: R01 for B/D, R02 for A/C
                  unique case (lvl)
                     shutdown_steering_pkg::LEVEL_HIGH: begin
                        switch_out_q.level[g] <= 1'b1; // R01 R02
                        switch_out_q.drive_en[g] <= 1'b1;
                     end
                     shutdown_steering_pkg::LEVEL_LOW: begin
                        switch_out_q.level[g] <= 1'b0; // R01 R02
                        switch_out_q.drive_en[g] <= 1'b1;
                     end
                     shutdown_steering_pkg::LEVEL_TRISTATE: begin
                        switch_out_q.level[g] <= 1'b0; // R01 R02
                        switch_out_q.drive_en[g] <= 1'b0;
                     end
                     shutdown_steering_pkg::LEVEL_INACTIVE: begin
                        switch_out_q.level[g] <= inactive; // R01 R02
                        switch_out_q.drive_en[g] <= 1'b1;
                     end
                  endcase
               end else begin
                  switch_out_q.level[g] <= norm & enable_q;
                  switch_out_q.drive_en[g] <= enable_q;
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   // Data stands for one cycle only and is zero otherwise, so a
   // stale value can never be taken for a fresh read; the steering
   // register reads the written buffer, not the active set
   always_comb begin
      reg_rdata_d = 8'h00;
      if (reg_read) begin
         unique case (reg_addr)
            shutdown_steering_pkg::IDX_CONTROL: begin
               reg_rdata_d = {enable_q, 4'h0, mode_q};
            end
            shutdown_steering_pkg::IDX_POLARITY: begin
               reg_rdata_d = {2'h0, waveform_gen_data, 1'b0,
                              output_invert_q};
            end
            shutdown_steering_pkg::IDX_SHUTDOWN_LEVELS: begin
               reg_rdata_d = {shutdown_q, restart_q, bd_shutdown_level_q,
                              ac_shutdown_level_q, 2'h0}; // R14
            end
            shutdown_steering_pkg::IDX_SOURCE_ENABLE: begin
               reg_rdata_d = {1'b0, source_shutdown_enable_q};
            end
            shutdown_steering_pkg::IDX_STEERING: begin
               reg_rdata_d = {override_level_q, steer_buffer_q};
            end
            default: begin
               reg_rdata_d = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         reg_rdata_q <= 8'h00;
      end else if (clk_en) begin
         reg_rdata_q <= reg_rdata_d;
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign switch_out = switch_out_q;

endmodule

// [tb/shutdown_steering_checker.sv]
`timescale 1ns/10ps
module shutdown_steering_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clk_en,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Data, sources and outputs
   input wire logic waveform_gen_data,
   input wire shutdown_steering_pkg::sources_t shutdown_sources,
   input wire shutdown_steering_pkg::outputs_t switch_out
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // ------------------------------------------------------------
   // Shadow of written fields, indexed by low address bits
   // ------------------------------------------------------------
   localparam logic [6:0] HI = shutdown_steering_pkg::ACTIVE_HIGH_SOURCES;
   logic [7:0] sh_q [5];
   logic [1:0] f;
   logic sd_now;
   logic lo_trip;
   logic hi_trip;
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sh_q <= '{8'h00, 8'h00, 8'h14, 8'h00, 8'h00};
      end else if (clk_en && reg_write && reg_addr >= 12'h610 &&
                   reg_addr <= 12'h614) begin
         sh_q[reg_addr[2:0]] <= reg_wdata;
      end
   end
   // True when every output shows its configured shutdown state
   always_comb begin
      sd_now = 1'b1;
      for (int i = 0; i < 4; i++) begin
         f = sh_q[2][2 + 2 * (i % 2) +: 2];
         if (f == 2'b01) begin
            sd_now &= !switch_out.drive_en[i];
         end else begin
            sd_now &= switch_out.drive_en[i] && switch_out.level[i] ==
                      (f == 2'b00 ? sh_q[1][i] : f[0]);
         end
      end
   end
   assign lo_trip = sh_q[0][7] && |(sh_q[3][6:0] & ~shutdown_sources & ~HI);
   assign hi_trip = sh_q[0][7] && |(sh_q[3][6:0] & shutdown_sources & HI);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   AST_RDATA_IDLE: assert property ($past(clk_en) && !$past(reg_read)
      |-> reg_rdata == 8'h00) else $error("read data outside read slot");
   AST_SRC_READBACK: assert property ($past(reg_read && clk_en &&
      reg_addr == 12'h613) |-> reg_rdata[6:0] == $past(sh_q[3][6:0]))
      else $error("source enable readback wrong");
   AST_LVL_READBACK: assert property ($past(reg_read && clk_en &&
      reg_addr == 12'h612) |-> reg_rdata[5:2] == $past(sh_q[2][5:2]))
      else $error("shutdown level readback wrong");
   AST_LOW_TRIP: assert property (clk_en && lo_trip && !reg_write ##1
      clk_en && !reg_write |=> sd_now) else $error("low source no trip");
   AST_HIGH_TRIP: assert property (clk_en && hi_trip && !reg_write ##1
      clk_en && !reg_write |=> sd_now) else $error("high source no trip");
   AST_SW_SHUTDOWN: assert property (clk_en && reg_write &&
      reg_addr == 12'h612 && reg_wdata[7] && !sh_q[0][7] ##1
      clk_en && !reg_write |=> sd_now) else $error("software set ignored");
   AST_HOLD: assert property (!waveform_gen_data [*4] ##0
      (clk_en && sd_now && !reg_write && !$past(reg_write)) |=> sd_now)
      else $error("shutdown left without data rise");
   AST_STATUS_SET: assert property ((lo_trip || hi_trip) && !reg_write
      ##1 reg_read && reg_addr == 12'h612 |=> reg_rdata[7])
      else $error("status not set by trip");
endmodule

// [tb/switch_driver_model.sv]
`timescale 1ns/10ps
module switch_driver_model (
   // Stage outputs
   input wire shutdown_steering_pkg::outputs_t switch_out,
   // Gate levels seen by the switches
   output logic [3:0] gate = 4'h0
);
   // A floating gate has no pull: show the inverse of its last value
   always @(switch_out) begin
      for (int i = 0; i < 4; i++) begin
         gate[i] = switch_out.drive_en[i] ? switch_out.level[i] : ~gate[i];
      end
   end
endmodule

// [tb/waveform_shutdown_steering_test.sv]
`timescale 1ns/10ps
module waveform_shutdown_steering_test;
   localparam logic [6:0] IDLE = ~shutdown_steering_pkg::ACTIVE_HIGH_SOURCES;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic clk_en = 1'b1;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic waveform_gen_data = 1'b0;
   shutdown_steering_pkg::sources_t shutdown_sources = IDLE;
   shutdown_steering_pkg::outputs_t switch_out;
   logic [3:0] gate;
   logic [7:0] lv_exp [4] = '{8'haf, 8'h00, 8'h0f, 8'hff};
   int error_cnt = 0;
   int compares = 0;
   waveform_shutdown_steering u_dut (.clk_sys(clk_sys), .resetn(resetn),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .waveform_gen_data(waveform_gen_data),
      .shutdown_sources(shutdown_sources), .switch_out(switch_out));
   switch_driver_model u_drv (.switch_out(switch_out), .gate(gate));
   initial forever #2 clk_sys = ~clk_sys;
   // ------------------------------------------------------------
   // Bus and compare helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      tick(1);
      reg_write <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      tick(1);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
      tick(1);
   endtask
   // Three cycles covers every output latency of the stage
   task automatic look(input logic [7:0] exp, input logic [7:0] m = 8'hff);
      tick(3);
      #1;
      chk(switch_out & m, exp);
      tick(1);
   endtask
   task automatic test_done;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      rd(12'h610, 8'h00);
      rd(12'h612, 8'h14);
      rd(12'h613, 8'h00);
      rd(12'h614, 8'h00);
      clk_en <= 1'b0;
      wr(12'h613, 8'h7f);
      clk_en <= 1'b1;
      rd(12'h613, 8'h00);
      wr(12'h615, 8'hff);
      rd(12'h615, 8'h00);
      wr(12'h614, 8'ha5);
      rd(12'h614, 8'ha5);
      $display("register test done");
   endtask
   task automatic t_steer;
      wr(12'h610, 8'h80);
      wr(12'h611, 8'h05);
      wr(12'h614, 8'ha3);
      for (int d = 0; d < 2; d++) begin
         waveform_gen_data <= d[0];
         look(d ? 8'haf : 8'h9f);
      end
      for (int m = 2; m < 6; m++) begin
         wr(12'h610, 8'h80 | m[7:0]);
         look(8'haf);
      end
      $display("steering test done");
   endtask
   task automatic t_sync;
      wr(12'h611, 8'h00);
      wr(12'h610, 8'h80);
      wr(12'h614, 8'h0f);
      wr(12'h610, 8'h81);
      wr(12'h614, 8'hf0);
      waveform_gen_data <= 1'b0;
      look(8'h0f);
      waveform_gen_data <= 1'b1;
      tick(2);
      waveform_gen_data <= 1'b0;
      look(8'hff);
      $display("sync steering test done");
   endtask
   task automatic t_trip;
      wr(12'h610, 8'h80);
      wr(12'h614, 8'h0f);
      wr(12'h612, 8'h6c);
      for (int i = 0; i < 7; i++) begin
         wr(12'h613, ~(8'h01 << i) & 8'h7f);
         shutdown_sources <= IDLE ^ (7'h01 << i);
         look(8'h0f);
         wr(12'h613, 8'h01 << i);
         rd(12'h612, 8'hec);
         look(8'h5f);
         shutdown_sources <= IDLE;
         look(8'h5f);
         rd(12'h612, 8'h6c);
         waveform_gen_data <= 1'b1;
         look(8'hff);
         waveform_gen_data <= 1'b0;
      end
      wr(12'h613, 8'h00);
      $display("trip test done");
   endtask
   task automatic t_levels;
      wr(12'h610, 8'h00);
      wr(12'h611, 8'h0a);
      for (int c = 0; c < 4; c++) begin
         wr(12'h612, 8'h80 | c[7:0] << 4 | c[7:0] << 2);
         look(lv_exp[c], c == 1 ? 8'h0f : 8'hff);
      end
      chk({4'h0, gate}, 8'h0f);
      wr(12'h612, 8'h3c);
      look(8'hff);
      waveform_gen_data <= 1'b1;
      look(8'h00, 8'h0f);
      waveform_gen_data <= 1'b0;
      $display("level test done");
   endtask
   initial begin
      tick(8);
      resetn <= 1'b1;
      tick(1);
      t_regs;
      t_steer;
      t_sync;
      t_trip;
      t_levels;
      test_done;
   end
   // The full run needs well under a thousand cycles
   initial begin
      tick(5000);
      error_cnt++;
      test_done;
   end
endmodule
bind waveform_shutdown_steering shutdown_steering_checker u_chk (
   .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata),
   .waveform_gen_data(waveform_gen_data),
   .shutdown_sources(shutdown_sources), .switch_out(switch_out));
